// [rtl/dbsm_pkg.sv]
// Purpose: Shared constants and types for the dual bus select and mode block.
// Assumes: Two transceiver lanes, byte-wide serial frames, most significant bit first.
// Notes:   Every width, count and encoding used by more than one file lives here.

package dbsm_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int         LANES      = 2;      // Transceivers on the board.
   localparam int         BYTE_BITS  = 8;      // Bits per serial word.
   localparam logic [2:0] BIT_FIRST  = 3'h0;   // Index of the first bit of a word.
   localparam logic [2:0] BIT_LAST   = 3'h7;   // Index of the last bit of a word.
   localparam int         FIFO_DEPTH = 2;      // Entries in the transmit buffer.
   localparam int         SYNC_PINS  = 5;      // Pins that pass the input synchroniser.

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   // Lane modes, Gray coded along off, sleep, normal.
   typedef enum logic [1:0] {
      MODE_OFF    = 2'h0,
      MODE_SLEEP  = 2'h1,
      MODE_NORMAL = 2'h3
   } dbsm_mode_type;

   // One received serial word and the lanes it was selected for.
   typedef struct packed {
      logic [LANES-1:0]     lanes;
      logic [BYTE_BITS-1:0] data;
   } dbsm_word_type;

   localparam int WORD_W = $bits(dbsm_word_type);  // Width of a buffered word.

endpackage

// [rtl/dbsm_fifo.sv]
// Purpose: Small first-in first-out buffer with valid and ready on both sides.
// Assumes: Single clock; writes and reads may happen in the same cycle.
// Notes:   Depth must be a power of two so that pointers wrap on their own.

`timescale 1ns/1ns

module dbsm_fifo
   import dbsm_pkg::*;
#(
   parameter int WIDTH = WORD_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   // Filling side.
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Draining side.
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;  // Pointer width.
   localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);  // Count when full.

   logic [WIDTH-1:0] store [DEPTH];   // Entry storage, no reset needed.
   logic [PW-1:0]    wr_ptr;          // Next entry to write.
   logic [PW-1:0]    rd_ptr;          // Oldest entry.
   logic [PW:0]      count;           // Entries held.
   logic [PW-1:0]    next_wr_ptr;     // Next write pointer.
   logic [PW-1:0]    next_rd_ptr;     // Next read pointer.
   logic [PW:0]      next_count;      // Next entry count.
   logic             push;            // Word accepted this cycle.
   logic             pop;             // Word delivered this cycle.

   // Full and empty come straight from the count, so they never lie.
   assign in_ready_out  = (count != FULL_COUNT);
   assign out_valid_out = (count != '0);
   assign out_data_out  = store[rd_ptr];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   // ---------------------------------------------------------------
   // Pointer and count update
   // ---------------------------------------------------------------
   // Next pointers and count.
   always_comb begin
      next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end

   // Register pointers and count.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage is written only; it holds data, not control state.
   always_ff @(posedge clk_in) begin
      if (push) begin
         store[wr_ptr] <= in_data_in;
      end
   end

endmodule

// [rtl/dbsm_top.sv]
// Purpose: Select decoder, mode control, wake interrupt and serial data path for two
//          transceivers that share one host transmit port.
// Assumes: The host clocks the transmit port; the bus front end works on clk_in.
// Contract
// - Enable high with supply: normal, indicator on.
// - Normal mode echoes sent bits on receive port.
// - Enable low: sleep; wake sequence asserts interrupt.
// - Interrupt holds low until enable rising edge.
// - Host and transmit selects are active low.
// - Select 0 picks first, 1 picks second.
// - Select 2 picks both transceivers together.
// - Each transmitted bit goes onto the bus; the code drops words whose lanes are not in normal mode.
// - Bus response bits go out on receive port; the code forwards them only for a lane in normal mode.

`timescale 1ns/1ns

module dbsm_top
   import dbsm_pkg::*;
(
   // Core clock and reset.
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   // Host transmit serial port.
   input  wire logic             tx_sclk_in,
   input  wire logic             tx_data_in,
   input  wire logic             host_select_first_n_in,
   input  wire logic             host_select_second_n_in,
   input  wire logic             host_select_both_n_in,
   output logic                  tx_ready_out,
   // Decoded transmit selects.
   output logic                  bus_one_tx_select_n_out,
   output logic                  bus_two_tx_select_n_out,
   // Mode pins.
   input  wire logic             bus_one_enable_in,
   input  wire logic             bus_two_enable_in,
   input  wire logic             io_supply_level_in,
   input  wire logic [LANES-1:0] bus_wake_detect_in,
   output logic      [LANES-1:0] mode_led_out,
   output logic                  bus_one_wake_irq_n_out,
   output logic                  bus_two_wake_irq_n_out,
   // Bus pulse side.
   output logic      [LANES-1:0] bus_bit_out,
   output logic      [LANES-1:0] bus_bit_valid_out,
   input  wire logic [LANES-1:0] bus_bit_ready_in,
   input  wire logic [LANES-1:0] bus_rx_bit_in,
   input  wire logic [LANES-1:0] bus_rx_strobe_in,
   // Host receive serial ports.
   output logic      [LANES-1:0] rx_sclk_out,
   output logic      [LANES-1:0] rx_data_out,
   output logic      [LANES-1:0] rx_select_n_out
);

   // ---------------------------------------------------------------
   // Select decoder
   // ---------------------------------------------------------------
   // A lane is selected by its own line or by the shared line; nothing is stored here.
   assign bus_one_tx_select_n_out = host_select_first_n_in & host_select_both_n_in;
   assign bus_two_tx_select_n_out = host_select_second_n_in & host_select_both_n_in;
   // All selects high leaves both outputs high; overlapping selects simply OR.
   logic frame_idle;   // High while no lane is selected.
   assign frame_idle = bus_one_tx_select_n_out & bus_two_tx_select_n_out;

   // ---------------------------------------------------------------
   // Link domain: shift in host bits
   // ---------------------------------------------------------------
   logic                 link_frame_rst_n;  // Clears the bit counter outside frames.
   logic [BYTE_BITS-1:0] link_shift;        // Bits gathered so far.
   logic [2:0]           link_count;        // Bits gathered in the current word.
   logic [BYTE_BITS-1:0] next_link_shift;   // Next shift value.
   logic [2:0]           next_link_count;   // Next bit count.
   dbsm_word_type        link_hold;         // Last whole word, stable for the core.
   logic                 link_toggle;       // Flips once per whole word.
   dbsm_word_type        next_link_hold;    // Next held word.
   logic                 next_link_toggle;  // Next toggle value.

   // The serial clock stops between frames, so the frame's own select ends a
   // partial word; a host must keep selects clean while the clock runs.
   assign link_frame_rst_n = resetn_in & ~frame_idle;

   // Next shift state and hand-off word.
   always_comb begin
      next_link_shift  = {link_shift[BYTE_BITS-2:0], tx_data_in};
      next_link_count  = 3'(link_count + 1'b1);
      next_link_hold   = link_hold;
      next_link_toggle = link_toggle;
      if (link_count == BIT_LAST) begin
         next_link_hold.data  = next_link_shift;
         next_link_hold.lanes = ~{bus_two_tx_select_n_out, bus_one_tx_select_n_out};
         next_link_toggle     = ~link_toggle;
      end
   end

   // Register the shift state; it lives only inside a frame.
   always_ff @(posedge tx_sclk_in or negedge link_frame_rst_n) begin
      if (!link_frame_rst_n) begin
         link_shift <= '0;
         link_count <= BIT_FIRST;
      end else begin
         link_shift <= next_link_shift;
         link_count <= next_link_count;
      end
   end

   // Register the hand-off word; it outlives the frame so the core can take it.
   always_ff @(posedge tx_sclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link_hold   <= '0;
         link_toggle <= 1'b0;
      end else begin
         link_hold   <= next_link_hold;
         link_toggle <= next_link_toggle;
      end
   end

   // ---------------------------------------------------------------
   // Core domain: synchronisers
   // ---------------------------------------------------------------
   logic [2:0]           tog_sync;     // Toggle synchroniser chain.
   logic                 tog_seen;     // Toggle value already taken.
   logic                 next_tog_seen;
   logic [SYNC_PINS-1:0] pin_raw;      // Pins gathered into one vector.
   logic [SYNC_PINS-1:0] pin_s0;       // First stage, read only by the second.
   logic [SYNC_PINS-1:0] pin_s1;       // Second stage.
   logic [SYNC_PINS-1:0] pin_s2;       // Third stage.
   logic [SYNC_PINS-1:0] pin_level;    // Accepted pin levels.
   logic [SYNC_PINS-1:0] next_pin_level;
   logic [LANES-1:0]     en_prev;      // Enable levels one cycle ago.
   logic                 word_arrived; // A new held word is safe to read.

   assign pin_raw = {bus_wake_detect_in, bus_two_enable_in, bus_one_enable_in,
                     io_supply_level_in};

   // A level counts only once the last two stages agree, filtering a late edge.
   always_comb begin
      next_pin_level = pin_level;
      for (int k = 0; k < SYNC_PINS; k++) begin
         if (pin_s1[k] == pin_s2[k]) begin
            next_pin_level[k] = pin_s2[k];
         end
      end
      word_arrived  = (tog_sync[1] == tog_sync[2]) && (tog_sync[2] != tog_seen);
      next_tog_seen = word_arrived ? tog_sync[2] : tog_seen;
   end

   // Register synchroniser stages and accepted levels.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tog_sync  <= '0;
         tog_seen  <= 1'b0;
         pin_s0    <= '0;
         pin_s1    <= '0;
         pin_s2    <= '0;
         pin_level <= '0;
         en_prev   <= '0;
      end else begin
         tog_sync  <= {tog_sync[1:0], link_toggle};
         tog_seen  <= next_tog_seen;
         pin_s0    <= pin_raw;
         pin_s1    <= pin_s0;
         pin_s2    <= pin_s1;
         pin_level <= next_pin_level;
         en_prev   <= pin_level[2:1];
      end
   end

   // ---------------------------------------------------------------
   // Pending word and transmit buffer
   // ---------------------------------------------------------------
   dbsm_word_type pend_word;       // Word waiting to enter the buffer.
   logic          pend_valid;      // Pending word present.
   dbsm_word_type next_pend_word;
   logic          next_pend_valid;
   logic          fifo_in_ready;   // Buffer has room.
   logic          fifo_out_valid;  // Buffer holds a word.
   logic          fifo_pop;        // Serializer finished a word.
   dbsm_word_type fifo_word;       // Oldest buffered word.

   // The host port cannot be stalled, so back-pressure shows on tx_ready_out;
   // a word that arrives while one is still pending overwrites it.
   assign tx_ready_out = ~pend_valid;

   // Next pending word.
   always_comb begin
      next_pend_word  = pend_word;
      next_pend_valid = pend_valid & ~fifo_in_ready;
      if (word_arrived) begin
         next_pend_word  = link_hold;
         next_pend_valid = 1'b1;
      end
   end

   // Register the pending word.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend_word  <= '0;
         pend_valid <= 1'b0;
      end else begin
         pend_word  <= next_pend_word;
         pend_valid <= next_pend_valid;
      end
   end

   dbsm_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_in        (clk_in),
      .resetn_in     (resetn_in),
      .in_valid_in   (pend_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (pend_word),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_word)
   );

   // ---------------------------------------------------------------
   // Serializer toward the bus
   // ---------------------------------------------------------------
   dbsm_mode_type    mode [LANES];   // Mode of each lane.
   logic [LANES-1:0] lane_normal;    // Lane is in normal mode.
   logic [LANES-1:0] lane_active;    // Lane takes the current word.
   logic [2:0]       ser_bit;        // Bit index within the word.
   logic [2:0]       next_ser_bit;
   logic             ser_bit_done;   // Current bit accepted by every active lane.
   logic             ser_value;      // Current bit value.

   assign lane_active       = fifo_word.lanes & lane_normal;
   assign ser_value         = fifo_word.data[3'(BIT_LAST - ser_bit)];
   assign bus_bit_out       = {LANES{ser_value}};
   assign bus_bit_valid_out = {LANES{fifo_out_valid}} & lane_active;

   // A word for sleeping lanes only is dropped at once rather than blocking the buffer.
   always_comb begin
      ser_bit_done = fifo_out_valid & (&(bus_bit_ready_in | ~lane_active));
      fifo_pop     = ser_bit_done & ((ser_bit == BIT_LAST) | (lane_active == '0));
      next_ser_bit = ser_bit;
      if (fifo_pop) begin
         next_ser_bit = BIT_FIRST;
      end else if (ser_bit_done) begin
         next_ser_bit = 3'(ser_bit + 1'b1);
      end
   end

   // Register the bit index.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ser_bit <= BIT_FIRST;
      end else begin
         ser_bit <= next_ser_bit;
      end
   end

   // ---------------------------------------------------------------
   // Per-lane mode, wake interrupt and receive port
   // ---------------------------------------------------------------
   logic [LANES-1:0] irq_n;  // Wake interrupt per lane.

   assign bus_one_wake_irq_n_out = irq_n[0];
   assign bus_two_wake_irq_n_out = irq_n[1];

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      dbsm_mode_type next_mode;     // Next lane mode.
      logic          next_irq_n;    // Next interrupt level.
      logic          en_level;      // Accepted enable level.
      logic          en_rise;       // Enable rising edge.
      logic          supply;        // Accepted supply level.
      logic          rx_event;      // A bit is due on the receive port.
      logic          rx_bit;        // Value of that bit.
      logic          rx_pulse;      // Clock high phase pending.
      logic          next_rx_data;
      logic          next_rx_pulse;
      logic          led;           // Indicator register.

      assign en_level             = pin_level[1 + i];
      assign supply               = pin_level[0];
      assign en_rise              = en_level & ~en_prev[i];
      assign lane_normal[i]       = (mode[i] == MODE_NORMAL);
      assign mode_led_out[i]      = led;
      assign rx_select_n_out[i]   = ~led;

      // Mode steps follow the supply and the enable level.
      always_comb begin
         next_mode  = mode[i];
         next_irq_n = irq_n[i];
         case (mode[i])
            MODE_OFF: begin
               if (supply) begin
                  next_mode = en_level ? MODE_NORMAL : MODE_SLEEP;
               end
            end
            MODE_SLEEP: begin
               if (!supply) begin
                  next_mode = MODE_OFF;
               end else if (en_rise) begin
                  next_mode = MODE_NORMAL;
               end else if (pin_level[3 + i]) begin
                  next_irq_n = 1'b0;
               end
            end
            MODE_NORMAL: begin
               if (!supply) begin
                  next_mode = MODE_OFF;
               end else if (!en_level) begin
                  next_mode = MODE_SLEEP;
               end
            end
            default: begin
               next_mode = MODE_OFF;
            end
         endcase
         // Only an enable rising edge releases the interrupt.
         if (en_rise) begin
            next_irq_n = 1'b1;
         end
      end

      // Echo wins over a bus bit in the same cycle; the bus front end spaces its
      // bits by at least two cycles, so a collision only occurs by misuse.
      always_comb begin
         rx_event      = 1'b0;
         rx_bit        = bus_rx_bit_in[i];
         if (ser_bit_done && lane_active[i]) begin
            rx_event = 1'b1;
            rx_bit   = ser_value;
         end else if (bus_rx_strobe_in[i] && lane_normal[i]) begin
            rx_event = 1'b1;
         end
         next_rx_data  = rx_event ? rx_bit : rx_data_out[i];
         next_rx_pulse = rx_event;
      end

      // Register mode, interrupt, indicator and receive port.
      always_ff @(posedge clk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            mode[i]        <= MODE_OFF;
            irq_n[i]       <= 1'b1;
            led            <= 1'b0;
            rx_data_out[i] <= 1'b0;
            rx_pulse       <= 1'b0;
            rx_sclk_out[i] <= 1'b0;
         end else begin
            mode[i]        <= next_mode;
            irq_n[i]       <= next_irq_n;
            led            <= (next_mode == MODE_NORMAL);
            rx_data_out[i] <= next_rx_data;
            rx_pulse       <= next_rx_pulse;
            rx_sclk_out[i] <= rx_pulse;
         end
      end
   end

endmodule

// [verif/dbsm_chk.sv]
// Purpose: Port assertions for the block.
// Assumes: A single clock domain at these ports.
// Notes:   Bound into the top module.
`timescale 1ns/1ns
module dbsm_chk
   import dbsm_pkg::*;
(
   // Watched ports.
   input wire logic       clk_in,
   input wire logic       resetn_in,
   input wire logic       host_select_first_n_in,
   input wire logic       host_select_second_n_in,
   input wire logic       host_select_both_n_in,
   input wire logic       bus_one_tx_select_n_out,
   input wire logic       bus_two_tx_select_n_out,
   input wire logic       bus_one_enable_in,
   input wire logic       io_supply_level_in,
   input wire logic [1:0] mode_led_out,
   input wire logic       bus_one_wake_irq_n_out,
   input wire logic [1:0] bus_bit_out,
   input wire logic [1:0] bus_bit_valid_out,
   input wire logic [1:0] bus_bit_ready_in,
   input wire logic [1:0] bus_rx_bit_in,
   input wire logic [1:0] bus_rx_strobe_in,
   input wire logic [1:0] rx_sclk_out,
   input wire logic [1:0] rx_data_out,
   input wire logic [1:0] rx_select_n_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Host selects decode to the transmit selects.
   a_sel_one: assert property (
      bus_one_tx_select_n_out == (host_select_first_n_in & host_select_both_n_in))
      else $error("select one");
   a_sel_two: assert property (
      bus_two_tx_select_n_out == (host_select_second_n_in & host_select_both_n_in))
      else $error("select two");
   // The indicator lights only with enable and supply.
   a_led_cause: assert property (
      $rose(mode_led_out[0]) |-> bus_one_enable_in && io_supply_level_in) else $error("led");
   // A wake falls only in sleep and rises only with enable.
   a_wake_dark: assert property (
      $fell(bus_one_wake_irq_n_out) |-> !mode_led_out[0]) else $error("wake");
   a_irq_hold: assert property (
      $rose(bus_one_wake_irq_n_out) |-> bus_one_enable_in) else $error("irq");
   // Accepted bits echo; offered bits hold.
   a_echo_bit: assert property (
      bus_bit_valid_out[0] && bus_bit_ready_in[0] |=> rx_data_out[0] == $past(bus_bit_out[0])
      ##1 rx_sclk_out[0] ##1 !rx_sclk_out[0]) else $error("echo");
   a_resp_bit: assert property (
      bus_rx_strobe_in[1] && !rx_select_n_out[1] && !bus_bit_valid_out[1] |=>
      rx_data_out[1] == $past(bus_rx_bit_in[1]) ##1 rx_sclk_out[1]) else $error("resp");
   a_bit_hold: assert property (
      bus_bit_valid_out[0] && !bus_bit_ready_in[0] |=> bus_bit_valid_out[0] &&
      $stable(bus_bit_out[0])) else $error("hold");
   // Main scenarios reached.
   c_wake: cover property (!bus_one_wake_irq_n_out);
   c_both: cover property (bus_bit_valid_out == 2'h3);
   c_resp: cover property (rx_sclk_out[1]);
endmodule
bind dbsm_top dbsm_chk i_dbsm_chk (.*);

// [verif/dbsm_host.sv]
// Purpose: Host model that sends serial words to the block.
// Assumes: Link clock of 64 ns that stands low between frames.
// Notes:   Unused selects stay high.
`timescale 1ns/1ns
module dbsm_host (
   // Link toward the block.
   output logic       sclk_out,
   output logic       data_out,
   output logic [2:0] sel_n_out
);
   // Idle link: clock low, selects high.
   initial begin
      sclk_out = 1'b0;
      data_out = 1'b0;
      sel_n_out = 3'h7;
   end
   // Sends one word MSB first; released data idles inverted.
   task automatic send(input logic [2:0] sel_n, input logic [7:0] word);
      #3 sel_n_out = sel_n;
      for (int i = 7; i >= 0; i--) begin
         #16 data_out = word[i];
         #16 sclk_out = 1'b1;
         #32 sclk_out = 1'b0;
      end
      #16 data_out = ~data_out;
      sel_n_out = 3'h7;
      #40;
   endtask
endmodule

// [verif/tb.sv]
// Purpose: Self-checking bench.
// Assumes: The bench plays both bus lanes.
// Notes:   The bus is ready one cycle in three.
`timescale 1ns/1ns
module tb;
   import dbsm_pkg::*;
   // Design ports, connected by name.
   logic             clk_in, resetn_in, tx_sclk_in, tx_data_in, tx_ready_out;
   logic             host_select_first_n_in, host_select_second_n_in, host_select_both_n_in;
   logic             bus_one_tx_select_n_out, bus_two_tx_select_n_out, io_supply_level_in;
   logic             bus_one_enable_in, bus_two_enable_in;
   logic             bus_one_wake_irq_n_out, bus_two_wake_irq_n_out;
   logic [LANES-1:0] bus_wake_detect_in, mode_led_out, bus_bit_out, bus_bit_valid_out;
   logic [LANES-1:0] bus_bit_ready_in, bus_rx_bit_in, bus_rx_strobe_in, rx_sclk_out;
   logic [LANES-1:0] rx_data_out, rx_select_n_out, rdy_en;
   logic [2:0]       sel_n;
   logic [23:0]      bus_sh [LANES];
   logic [7:0]       rx_sh [LANES];
   int               bus_n [LANES];
   int               fail_count, compares, cycles;

   assign {host_select_both_n_in, host_select_second_n_in, host_select_first_n_in} = sel_n;
   dbsm_top  i_dbsm_top (.*);
   dbsm_host i_dbsm_host (.sclk_out(tx_sclk_in), .data_out(tx_data_in), .sel_n_out(sel_n));

   // Core clock, 8 ns.
   always #4 clk_in = ~clk_in;

   // Bus side: paced readiness, bit collection, hang guard.
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      bus_bit_ready_in <= (cycles % 3 == 0) ? rdy_en : 2'h0;
      for (int l = 0; l < LANES; l++) begin
         if (bus_bit_valid_out[l] && bus_bit_ready_in[l]) begin
            bus_sh[l] <= {bus_sh[l][22:0], bus_bit_out[l]};
            bus_n[l] <= bus_n[l] + 1;
         end
         if (rx_sclk_out[l]) begin
            rx_sh[l] <= {rx_sh[l][6:0], rx_data_out[l]};
         end
      end
      if (cycles == 5000) begin
         fail_count++;
         final_report();
      end
   end

   // One comparison; an unknown bit matches only the same unknown in the expected value.
   task automatic chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   // Waits n rising edges, then a falling edge.
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask

   // Each select alone, then all idle.
   task automatic t_decode();
      logic [2:0] code [4] = '{3'h6, 3'h5, 3'h3, 3'h7};
      logic [1:0] want [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_in) i_dbsm_host.sel_n_out <= code[k];
         @(negedge clk_in);
         chk("tx selects", want[k], {bus_two_tx_select_n_out, bus_one_tx_select_n_out});
      end
   endtask

   // Normal mode needs supply: leds drop without it and return with it.
   task automatic t_mode();
      settle(10);
      chk("leds", 2'h3, mode_led_out);
      @(posedge clk_in) io_supply_level_in <= 1'b0;
      settle(10);
      chk("leds no supply", 2'h0, mode_led_out);
      @(posedge clk_in) io_supply_level_in <= 1'b1;
      settle(10);
      chk("leds again", 2'h3, mode_led_out);
   endtask

   // A word to lane one, then to both; each is echoed.
   task automatic t_echo();
      int n0 = bus_n[0];
      int n1 = bus_n[1];
      i_dbsm_host.send(3'h6, 8'hA5);
      settle(40);
      chk("lane one word", 8'hA5, bus_sh[0][7:0]);
      chk("lane two idle", n1, bus_n[1]);
      chk("echo one", 8'hA5, rx_sh[0]);
      i_dbsm_host.send(3'h3, 8'h3C);
      settle(40);
      chk("lane one bits", n0 + 16, bus_n[0]);
      chk("lane two word", 8'h3C, bus_sh[1][7:0]);
      chk("echo two", 8'h3C, rx_sh[1]);
   endtask

   // Stalled bus: three words queue, then drain in order.
   task automatic t_stall();
      @(posedge clk_in) rdy_en <= 2'h0;
      i_dbsm_host.send(3'h6, 8'h81);
      i_dbsm_host.send(3'h6, 8'h42);
      i_dbsm_host.send(3'h6, 8'h18);
      settle(10);
      chk("tx ready full", 1'h0, tx_ready_out);
      chk("offer held", 3'h3, {bus_bit_valid_out, bus_bit_out[0]});
      @(posedge clk_in) rdy_en <= 2'h3;
      settle(100);
      chk("drained words", 24'h814218, bus_sh[0]);
      chk("tx ready free", 1'h1, tx_ready_out);
   endtask

   // Response bits on lane two reach the host.
   task automatic t_resp();
      logic [7:0] w = 8'hC3;
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_in) bus_rx_bit_in[1] <= w[i];
         bus_rx_strobe_in[1] <= 1'b1;
         @(posedge clk_in) bus_rx_strobe_in[1] <= 1'b0;
         bus_rx_bit_in[1] <= ~w[i];
         settle(2);
      end
      settle(4);
      chk("response two", 8'hC3, rx_sh[1]);
   endtask

   // Sleep, wake, hold, and release by an enable rising edge.
   task automatic t_wake();
      logic [7:0] r0 = rx_sh[0];
      @(posedge clk_in) bus_one_enable_in <= 1'b0;
      settle(10);
      chk("leds sleep", 4'h9, {mode_led_out, rx_select_n_out});
      @(posedge clk_in) bus_rx_strobe_in[0] <= 1'b1;
      bus_wake_detect_in[0] <= 1'b1;
      @(posedge clk_in) bus_rx_strobe_in[0] <= 1'b0;
      settle(6);
      chk("irq raised", 2'h2, {bus_two_wake_irq_n_out, bus_one_wake_irq_n_out});
      @(posedge clk_in) bus_wake_detect_in[0] <= 1'b0;
      settle(30);
      chk("irq held", 1'h0, bus_one_wake_irq_n_out);
      chk("sleep strobe", r0, rx_sh[0]);
      @(posedge clk_in) bus_one_enable_in <= 1'b1;
      settle(10);
      chk("irq released", 1'h1, bus_one_wake_irq_n_out);
      chk("leds back", 2'h3, mode_led_out);
   endtask

   // Prints counts and verdict, then ends the run.
   task automatic final_report();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      clk_in = 1'b0;
      resetn_in = 1'b0;
      {bus_one_enable_in, bus_two_enable_in, io_supply_level_in} = 3'h7;
      {bus_wake_detect_in, bus_rx_bit_in, bus_rx_strobe_in} = 6'h0;
      rdy_en = 2'h3;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      t_decode();
      t_mode();
      t_echo();
      t_stall();
      t_resp();
      t_wake();
      final_report();
   end
endmodule
